// [hw/fpwc_top.v]
// Frequency and pulse-width measurement counter channel with an APB slave.
// Assumes three asynchronous field inputs, one 250 MHz clock and a pull-up
// on the output pin, which is driven only while the completion pulse lasts.
//
// Function
// - Mode 100 with source 111 measures frequency.
// - Count counted-input edges while gate active.
// - Gate end gives 1.6us pulse, optional interrupt.
// - Bit 3 sets output active level; idles high.
// - Bits 5..4 set gate enable polarity.
// - Bits 7..6 set counted input polarity.
// - Bits 9..8 set external trigger polarity.
// - Debounce rejects pulses up to 2.4us.
// - Bit 15 gates interrupts, default off.
// - Mode 101 measures pulse width.
// - Measure first whole active pulse after trigger.
// - External clock needs polarity and source 101.
// - Internal timebases from 1.25 to 20 MHz.
// - Source codes 000 to 101 pick the clock.
// - Software trigger by writing offset 1Ch.
// - Trigger clears count, counts while active.
// - Completion emits a pulse; count may err by one.
// - Count saturates at all ones for size.
// - Interrupt needs bit 15 and global bit 0.
// - Interrupt pends until status bit written.
// - Writing bit 15 low clears pending interrupt.
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`include "fpwc_defs.vh"

module fpwc_top #(
  parameter DEB_CYC   = `FPWC_DEB_CYC,
  parameter PULSE_CYC = `FPWC_PULSE_CYC
) (
  input  wire        clk_i,
  input  wire        resetn_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  input  wire        gate_pulse_input_i,
  input  wire        counted_or_clock_input_i,
  input  wire        trigger_input_i,
  output wire        out_o,
  output wire        out_oe_o,
  output wire        irq_o
);

  localparam ST_IDLE  = 2'h0;
  localparam ST_ARMED = 2'h1;
  localparam ST_RUN   = 2'h2;

  // Timebase dividers as plain integers, cut to the divider width where used.
  localparam HDIV0 = `FPWC_HDIV0;
  localparam HDIV1 = `FPWC_HDIV1;
  localparam HDIV2 = `FPWC_HDIV2;
  localparam HDIV3 = `FPWC_HDIV3;
  localparam HDIV4 = `FPWC_HDIV4;

  // True when the synchronised level is at its programmed active level.
  function act;
    input       lvl;
    input [1:0] pol;
    begin
      act = (pol == `FPWC_POL_LOW) ? ~lvl : ((pol == `FPWC_POL_HIGH) ? lvl : 1'b0);
    end
  endfunction

  // Divider of the internal timebase, in half clock periods.
  function [8:0] hdiv;
    input [2:0] src;
    begin
      case (src)
        3'h0:    hdiv = HDIV0[8:0];
        3'h1:    hdiv = HDIV1[8:0];
        3'h2:    hdiv = HDIV2[8:0];
        3'h3:    hdiv = HDIV3[8:0];
        default: hdiv = HDIV4[8:0];
      endcase
    end
  endfunction

  reg  [2:0]  s1_q;
  reg  [2:0]  s2_q;
  reg  [2:0]  filt_q;
  reg  [2:0]  prev_q;
  reg  [15:0] db_cnt_q [0:2];
  reg  [15:0] ctrl_q;
  reg         gie_q;
  reg         pend_q;
  reg  [1:0]  st_q;
  reg  [31:0] cnt_q;
  reg  [8:0]  acc_q;
  reg  [15:0] pls_q;
  reg         drv_q;
  reg         lvl_q;
  reg  [31:0] rdata_q;
  integer     i;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus decode.

  wire acc_w   = psel_i & penable_i;
  wire wr_w    = acc_w & pwrite_i;
  wire hit_w   = (paddr_i == `FPWC_GIE_OFS) | (paddr_i == `FPWC_STAT_OFS) |
                 (paddr_i == `FPWC_TRIG_OFS) | (paddr_i == `FPWC_CTRL_OFS) |
                 (paddr_i == `FPWC_CNT_OFS);
  wire wr_ctrl = wr_w & (paddr_i == `FPWC_CTRL_OFS);
  wire wr_stat = wr_w & (paddr_i == `FPWC_STAT_OFS);
  wire sw_trig = wr_w & (paddr_i == `FPWC_TRIG_OFS);

  // Zero wait states; unmapped addresses answer with an error.
  assign pready_o  = 1'b1;
  assign pslverr_o = acc_w & ~hit_w;
  assign prdata_o  = rdata_q;

  // Read data is captured in the setup cycle and stands through the access.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      rdata_q <= 32'h00000000;
    end else if (psel_i & ~penable_i) begin
      case (paddr_i)
        `FPWC_GIE_OFS:  rdata_q <= {31'h00000000, gie_q};
        `FPWC_STAT_OFS: rdata_q <= {29'h00000000, st_q, pend_q};
        `FPWC_CTRL_OFS: rdata_q <= {16'h0000, ctrl_q};
        `FPWC_CNT_OFS:  rdata_q <= cnt_q;
        default:        rdata_q <= 32'h00000000;
      endcase
    end
  end

  // Control and global interrupt enable registers.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      ctrl_q <= `FPWC_CTRL_RST;
      gie_q  <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= pwdata_i[15:0];
      end
      if (wr_w & (paddr_i == `FPWC_GIE_OFS)) begin
        gie_q <= pwdata_i[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input conditioning.

  // Two flops on each field input before anything looks at it.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
    end else begin
      s1_q <= {trigger_input_i, counted_or_clock_input_i, gate_pulse_input_i};
      s2_q <= s1_q;
    end
  end

  // With bit 13 set, a new level is accepted only after it has stood longer than the window.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      filt_q <= 3'h0;
      prev_q <= 3'h0;
      for (i = 0; i < 3; i = i + 1) begin
        db_cnt_q[i] <= 16'h0000;
      end
    end else begin
      prev_q <= filt_q;
      for (i = 0; i < 3; i = i + 1) begin
        if (!ctrl_q[`FPWC_DEB_BIT] || (s2_q[i] == filt_q[i])) begin
          filt_q[i]   <= ctrl_q[`FPWC_DEB_BIT] ? filt_q[i] : s2_q[i];
          db_cnt_q[i] <= 16'h0000;
        end else if (db_cnt_q[i] == DEB_CYC[15:0]) begin
          filt_q[i]   <= s2_q[i];
          db_cnt_q[i] <= 16'h0000;
        end else begin
          db_cnt_q[i] <= db_cnt_q[i] + 16'h0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode and events.

  wire [2:0] mode_w = ctrl_q[`FPWC_MODE_MSB:`FPWC_MODE_LSB];
  wire [2:0] src_w  = ctrl_q[`FPWC_SRC_MSB:`FPWC_SRC_LSB];
  wire [1:0] apol_w = ctrl_q[`FPWC_APOL_MSB:`FPWC_APOL_LSB];
  wire [1:0] bpol_w = ctrl_q[`FPWC_BPOL_MSB:`FPWC_BPOL_LSB];
  wire [1:0] cpol_w = ctrl_q[`FPWC_CPOL_MSB:`FPWC_CPOL_LSB];
  wire fm_w = (mode_w == `FPWC_MODE_FREQ) & (src_w == `FPWC_SRC_FREQ);
  wire pw_w = (mode_w == `FPWC_MODE_PW);

  // Gate level and its leading edge, by programmed polarity.
  wire gate_w  = act(filt_q[0], apol_w);
  wire gate_up = gate_w & ~act(prev_q[0], apol_w);
  // Edge of the counted or clock input into its active level.
  wire b_edge  = act(filt_q[1], bpol_w) & ~act(prev_q[1], bpol_w);
  // External trigger edge; codes 00 and 11 never fire.
  wire c_edge  = act(filt_q[2], cpol_w) & ~act(prev_q[2], cpol_w);
  wire trig_w  = (fm_w | pw_w) & (sw_trig | c_edge);

  ////////////////////////////////////////////////////////////////////////////
  // Internal timebase and count tick.

  wire [8:0] div_w  = hdiv(src_w);
  wire [8:0] nacc_w = acc_q + 9'h002;
  wire       tb_w   = (nacc_w >= div_w);
  wire       ext_w  = (src_w == `FPWC_SRC_EXT) &
                      ((bpol_w == `FPWC_POL_LOW) | (bpol_w == `FPWC_POL_HIGH));
  reg        tick_w;

  // Pick what advances the count in each mode.
  always @* begin
    if (fm_w) begin
      tick_w = b_edge;
    end else if (ext_w) begin
      tick_w = b_edge;
    end else if (src_w <= 3'h4) begin
      tick_w = tb_w;
    end else begin
      tick_w = 1'b0;
    end
  end

  // Fractional divider: adds two half periods each cycle.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      acc_q <= 9'h000;
    end else if (st_q != ST_RUN) begin
      acc_q <= 9'h000;
    end else if (tb_w) begin
      acc_q <= nacc_w - div_w;
    end else begin
      acc_q <= nacc_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Measurement sequence.

  wire [31:0] max_w  = ctrl_q[`FPWC_SIZE_BIT] ? `FPWC_CNT32_MAX : `FPWC_CNT16_MAX;
  wire        done_w = (st_q == ST_RUN) & ~gate_w & (fm_w | pw_w);

  // Trigger arms, the gate's leading edge starts, its end completes.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      st_q  <= ST_IDLE;
      cnt_q <= 32'h00000000;
    end else if (!(fm_w | pw_w)) begin
      st_q <= ST_IDLE;
    end else if (trig_w) begin
      st_q  <= ST_ARMED;
      cnt_q <= 32'h00000000;
    end else begin
      case (st_q)
        ST_ARMED: begin
          if (gate_up) begin
            st_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!gate_w) begin
            st_q <= ST_IDLE;
          end else if (tick_w && (cnt_q < max_w)) begin
            cnt_q <= cnt_q + 32'h00000001;
          end else if (cnt_q > max_w) begin
            cnt_q <= max_w;
          end
        end
        ST_IDLE: begin
          st_q <= ST_IDLE;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Completion pulse and interrupt.

  // The pin is driven to the active level for the pulse, else released.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      pls_q <= 16'h0000;
      drv_q <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      lvl_q <= ctrl_q[`FPWC_OPOL_BIT];
      if (done_w) begin
        pls_q <= PULSE_CYC[15:0];
        drv_q <= 1'b1;
      end else if (pls_q > 16'h0001) begin
        pls_q <= pls_q - 16'h0001;
      end else begin
        pls_q <= 16'h0000;
        drv_q <= 1'b0;
      end
    end
  end

  assign out_o    = lvl_q;
  assign out_oe_o = drv_q;

  // Pending flag; a completion in the clearing cycle still sets it.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      pend_q <= 1'b0;
    end else if (done_w & ctrl_q[`FPWC_IE_BIT] & gie_q) begin
      pend_q <= 1'b1;
    end else if ((wr_stat & pwdata_i[0]) | (wr_ctrl & ~pwdata_i[`FPWC_IE_BIT])) begin
      pend_q <= 1'b0;
    end
  end

  assign irq_o = pend_q;

endmodule

// [shared/fpwc_defs.vh]
// Constants of the frequency and pulse-width counter channel.
// Assumes a 250 MHz core clock and an APB register port with byte addresses.
`ifndef FPWC_DEFS_VH
`define FPWC_DEFS_VH

// Register byte offsets.
`define FPWC_GIE_OFS     8'h00
`define FPWC_STAT_OFS    8'h04
`define FPWC_TRIG_OFS    8'h1c
`define FPWC_CTRL_OFS    8'h20
`define FPWC_CNT_OFS     8'h24

// Control fields.
`define FPWC_MODE_MSB    2
`define FPWC_MODE_LSB    0
`define FPWC_OPOL_BIT    3
`define FPWC_APOL_MSB    5
`define FPWC_APOL_LSB    4
`define FPWC_BPOL_MSB    7
`define FPWC_BPOL_LSB    6
`define FPWC_CPOL_MSB    9
`define FPWC_CPOL_LSB    8
`define FPWC_SRC_MSB     12
`define FPWC_SRC_LSB     10
`define FPWC_DEB_BIT     13
`define FPWC_SIZE_BIT    14
`define FPWC_IE_BIT      15
`define FPWC_CTRL_RST    16'h0000

// Mode and source codes.
`define FPWC_MODE_FREQ   3'h4
`define FPWC_MODE_PW     3'h5
`define FPWC_SRC_FREQ    3'h7
`define FPWC_SRC_EXT     3'h5
`define FPWC_POL_LOW     2'h1
`define FPWC_POL_HIGH    2'h2
`define FPWC_CNT16_MAX   32'h0000ffff
`define FPWC_CNT32_MAX   32'hffffffff

// Timing, derived from the clock rate.
`define FPWC_CLK_KHZ     250000
`define FPWC_DEB_NS      2400
`define FPWC_DEB_CYC     ((`FPWC_DEB_NS * (`FPWC_CLK_KHZ / 1000)) / 1000)
`define FPWC_PULSE_NS    1600
`define FPWC_PULSE_CYC   ((`FPWC_PULSE_NS * (`FPWC_CLK_KHZ / 1000)) / 1000)
// Timebase dividers in half clock periods, so that 20 MHz divides exactly.
`define FPWC_HDIV0       ((2 * `FPWC_CLK_KHZ) / 1250)
`define FPWC_HDIV1       ((2 * `FPWC_CLK_KHZ) / 2500)
`define FPWC_HDIV2       ((2 * `FPWC_CLK_KHZ) / 5000)
`define FPWC_HDIV3       ((2 * `FPWC_CLK_KHZ) / 10000)
`define FPWC_HDIV4       ((2 * `FPWC_CLK_KHZ) / 20000)

`endif

// [test/fpwc_assertions.sv]
// Checker for the counter channel: APB answer, completion pulse, interrupt.
// Assumes the bench shortens PULSE_CYC to 4.
`timescale 1ns/100ps
`include "fpwc_defs.vh"
module fpwc_checker #(
  parameter DEB_CYC   = 4,
  parameter PULSE_CYC = 4
) (
  input wire        clk_i,
  input wire        resetn_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire        pwrite_i,
  input wire [7:0]  paddr_i,
  input wire [31:0] pwdata_i,
  input wire [31:0] prdata_o,
  input wire        pready_o,
  input wire        pslverr_o,
  input wire        gate_pulse_input_i,
  input wire        counted_or_clock_input_i,
  input wire        trigger_input_i,
  input wire        out_o,
  input wire        out_oe_o,
  input wire        irq_o
);
  ////////////////////////////////
  // Access phase, control writes and the two ways of dropping a pending request.
  wire acc = psel_i && penable_i;
  wire wrc = acc && pwrite_i && (paddr_i == `FPWC_CTRL_OFS);
  wire clr = (acc && pwrite_i && (paddr_i == `FPWC_STAT_OFS) && pwdata_i[0]) ||
             (wrc && !pwdata_i[`FPWC_IE_BIT]);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  a_ready_zero: assert property (acc |-> pready_o)
    else $error("pready low in access.");
  a_err_access: assert property (pslverr_o |-> acc)
    else $error("error flag outside access.");
  a_pulse_len: assert property ($rose(out_oe_o) |-> out_oe_o [*4] ##1 !out_oe_o)
    else $error("completion pulse length wrong.");
  a_out_level: assert property (wrc |-> ##2 out_o == $past(pwdata_i[3], 2))
    else $error("output level not from control.");
  a_irq_clear: assert property (clr |=> !irq_o || $rose(out_oe_o))
    else $error("pending request not cleared.");
  a_irq_hold: assert property (irq_o && !clr |=> irq_o)
    else $error("pending request lost.");
  a_irq_cause: assert property ($rose(irq_o) |-> $rose(out_oe_o))
    else $error("interrupt without completion.");
  a_ie_off: assert property ((wrc && !pwdata_i[15]) ##1 (!wrc && !$rose(out_oe_o)) [*2] |=> !irq_o)
    else $error("interrupt while service off.");
  c_pulse: cover property ($rose(out_oe_o));
  c_irq: cover property ($rose(irq_o));
  c_clear: cover property (clr && irq_o);
endmodule
bind fpwc_top fpwc_checker #(.DEB_CYC(DEB_CYC), .PULSE_CYC(PULSE_CYC)) u_chk (
  .clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
  .pready_o, .pslverr_o, .gate_pulse_input_i, .counted_or_clock_input_i,
  .trigger_input_i, .out_o, .out_oe_o, .irq_o);

// [test/fpwc_field_src.sv]
// Field sources for the gate, counted and trigger inputs of the channel.
// Assumes the bench calls its tasks just after a rising edge.
`timescale 1ns/100ps
module fpwc_field_src (
  input  wire  clk_i,
  output logic gate_o,
  output logic cnt_o,
  output logic trig_o
);
  ////////////////////////////////
  // All lines start low.
  initial begin
    gate_o = 1'b0;
    cnt_o  = 1'b0;
    trig_o = 1'b0;
  end
  // Idles both lines, holds the gate active around n counted pulses, releases it.
  task automatic run(input logic ga, input logic ba, input int lead, input int n,
                     input int hi, input int lo);
    gate_o <= ~ga;
    cnt_o  <= ~ba;
    repeat (8) @(posedge clk_i);
    gate_o <= ga;
    repeat (lead) @(posedge clk_i);
    repeat (n) begin
      cnt_o <= ba;
      repeat (hi) @(posedge clk_i);
      cnt_o <= ~ba;
      repeat (lo) @(posedge clk_i);
    end
    repeat (lead) @(posedge clk_i);
    gate_o <= ~ga;
    @(posedge clk_i);
  endtask
  // One trigger pulse of 8 cycles at the given active level.
  task automatic trig(input logic ta);
    trig_o <= ta;
    repeat (8) @(posedge clk_i);
    trig_o <= ~ta;
    repeat (8) @(posedge clk_i);
  endtask
endmodule

// [test/test_freq_and_pulse_width_counter.sv]
// Bench for the counter channel: APB master, field sources and scenarios.
// Assumes fpwc_top with DEB_CYC and PULSE_CYC shortened to 4.
`timescale 1ns/100ps
`include "fpwc_defs.vh"
module test_freq_and_pulse_width_counter;
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] rd;
  logic        last_err;
  wire  [31:0] prdata_o;
  wire         pready_o, pslverr_o, gate, cnt, trg, out_o, out_oe_o, irq_o;
  int          errors = 0;
  int          n_compared = 0;
  int          k;
  ////////////////////////////////
  // Clock of 4 ns.
  always #2 clk_i = ~clk_i;
  fpwc_top #(.DEB_CYC(4), .PULSE_CYC(4)) dut_u (
    .clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .gate_pulse_input_i(gate), .counted_or_clock_input_i(cnt),
    .trigger_input_i(trg), .out_o, .out_oe_o, .irq_o);
  fpwc_field_src src_u (.clk_i, .gate_o(gate), .cnt_o(cnt), .trig_o(trg));
  // Closing report.
  task automatic end_sim();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Compares a value with its expectation.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // Accepts a count one off either way.
  task automatic near(input logic [31:0] seen, input logic [31:0] exp);
    check((seen - exp + 32'h1) <= 32'h2, 32'h1);
  endtask
  // One APB transfer, held until pready is seen at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (pready_o !== 1'b1 && i < 50);
    if (i == 50) begin
      errors++;
      end_sim();
    end
    rd = prdata_o;
    last_err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // Waits for the completion pulse, checks pin level, interrupt and release.
  task automatic done(input logic act, input logic irq);
    int i;
    for (i = 0; i < 99 && out_oe_o !== 1'b1; i++) @(posedge clk_i);
    if (i == 99) begin
      errors++;
      end_sim();
    end
    check(out_o, act);
    check(irq_o, irq);
    repeat (8) @(posedge clk_i);
    check(out_oe_o, 1'b0);
  endtask
  // Reset value of control and a refused access.
  task automatic t_reset();
    apb(1'b0, `FPWC_CTRL_OFS, 32'h0);
    check(rd, `FPWC_CTRL_RST);
    apb(1'b0, 8'h40, 32'h0);
    check(last_err, 1'b1);
  endtask
  // Pulse width on every timebase, an untriggered pulse, clears via status and control.
  task automatic t_pw_int();
    apb(1'b1, `FPWC_GIE_OFS, 32'h1);
    // An all-ones reading would call for a slower timebase and a repeat.
    for (k = 0; k < 5; k++) begin
      apb(1'b1, `FPWC_CTRL_OFS, 32'h8025 | (k << 10));
      apb(1'b1, `FPWC_TRIG_OFS, 32'h0);
      src_u.run(1'b1, 1'b1, 500, 0, 0, 0);
      done(1'b0, 1'b1);
      apb(1'b0, `FPWC_CNT_OFS, 32'h0);
      near(rd, 32'h5 << k);
      if (k < 4) begin
        apb(1'b1, `FPWC_STAT_OFS, 32'h1);
        check(irq_o, 1'b0);
      end
    end
    // A long untriggered pulse would add many ticks if it were counted.
    src_u.run(1'b1, 1'b1, 100, 0, 0, 0);
    apb(1'b0, `FPWC_CNT_OFS, 32'h0);
    near(rd, 32'h50);
    apb(1'b1, `FPWC_CTRL_OFS, 32'h1025);
    check(irq_o, 1'b0);
  endtask
  // External trigger and clock, gate active at trigger, clear via status.
  task automatic t_pw_ext();
    apb(1'b1, `FPWC_CTRL_OFS, 32'h9695);
    src_u.trig(1'b1);
    src_u.run(1'b0, 1'b1, 20, 10, 3, 3);
    done(1'b0, 1'b1);
    apb(1'b1, `FPWC_STAT_OFS, 32'h1);
    check(irq_o, 1'b0);
    apb(1'b0, `FPWC_CNT_OFS, 32'h0);
    near(rd, 32'ha);
  endtask
  // Frequency count without and with debounce, interrupt service off.
  task automatic t_freq();
    for (k = 0; k < 2; k++) begin
      apb(1'b1, `FPWC_CTRL_OFS, 32'h1c5c | (k << 13));
      apb(1'b1, `FPWC_TRIG_OFS, 32'h0);
      src_u.run(1'b0, 1'b0, 20, 7, 3, 3);
      done(1'b1, 1'b0);
      apb(1'b0, `FPWC_CNT_OFS, 32'h0);
      check(rd, k ? 32'h0 : 32'h7);
    end
  endtask
  // Main sequence.
  initial begin
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    t_reset();
    t_pw_int();
    t_pw_ext();
    t_freq();
    end_sim();
  end
endmodule
